// ===== rtl/fifo_flag_pkg.sv
package fifo_flag_pkg;

   // ----------------------------------------------------------------
   // Widths and depth
   // ----------------------------------------------------------------
   localparam int DATA_W = 18;
   localparam int BASE_DEPTH = 512;
   // Wide enough for the doubled depth plus the wrap bit
   localparam int PTR_W = 11;

   // ----------------------------------------------------------------
   // Flag values after either reset (active-low flags)
   // ----------------------------------------------------------------
   localparam logic RST_EMPTY_N = 1'h0;
   localparam logic RST_READY_OUT_N = 1'h1;
   localparam logic RST_FULL_N = 1'h1;
   localparam logic RST_READY_IN_N = 1'h0;
   localparam logic RST_AE_N = 1'h0;
   localparam logic RST_AF_N = 1'h1;
   localparam logic RST_HF_N = 1'h1;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic {
      MODE_STANDARD = 1'h0,
      MODE_FIRST_WORD_FALLTHROUGH_MODE = 1'h1
   } mode_type;

   // Every pin that arrives from outside the system clock
   typedef struct packed {
      logic wclk;
      logic wen_n;
      logic [DATA_W-1:0] din;
      logic rclk;
      logic ren_n;
      logic mode;
      logic mrst_n;
   } pin_type;

   localparam pin_type PIN_RST = '{
      wclk: 1'h0, wen_n: 1'h1, din: 18'h00000,
      rclk: 1'h0, ren_n: 1'h1, mode: 1'h0, mrst_n: 1'h1};

   typedef struct packed {
      pin_type s1;
      pin_type s2;
   } sync_state_type;

   typedef struct packed {
      mode_type mode;
      logic wclk_prev;
      logic rclk_prev;
      logic [PTR_W-1:0] wptr;
      logic [PTR_W-1:0] wptr_g;
      logic [PTR_W-1:0] rptr;
      logic [PTR_W-1:0] rptr_g;
      logic [PTR_W-1:0] wg_s1;
      logic [PTR_W-1:0] wg_s2;
      logic [PTR_W-1:0] rg_s1;
      logic [PTR_W-1:0] rg_s2;
      logic out_valid;
      logic [DATA_W-1:0] data_out;
      logic ef_n;
      logic ff_n;
      logic ae_n;
      logic af_n;
      logic hf_n;
   } fifo_state_type;

   // ----------------------------------------------------------------
   // Gray code helpers
   // ----------------------------------------------------------------
   function automatic logic [PTR_W-1:0] bin2gray(
      input logic [PTR_W-1:0] b);
      return b ^ (b >> 1);
   endfunction

   function automatic logic [PTR_W-1:0] gray2bin(
      input logic [PTR_W-1:0] g);
      logic [PTR_W-1:0] b;
      b[PTR_W-1] = g[PTR_W-1];
      for (int i = PTR_W - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

endpackage

// ===== rtl/pin_sync.sv
module pin_sync
   import fifo_flag_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire pin_type i_pins,
   output pin_type o_pins
);

   // ----------------------------------------------------------------
   // Two-stage synchroniser for all foreign pins
   // ----------------------------------------------------------------
   sync_state_type st;
   sync_state_type next_st;

   // Stage one feeds stage two only, never any logic
   always_comb begin
      next_st = st;
      next_st.s1 = i_pins;
      next_st.s2 = st.s1;
   end

   // Both stages hold while the clock enable is low
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st <= '{s1: PIN_RST, s2: PIN_RST};
      end else if (i_ce) begin
         st <= next_st;
      end
   end

   assign o_pins = st.s2;

endmodule

// ===== rtl/dual_clock_fifo_flag_logic.sv
// Notes on behaviour
// - Mode pin latched during master reset
// - Fall-through: first word out after three edges
// - Write enable low captures data per edge
// - Standard: empty flag rises after first write
// - Almost-empty rises at offset plus one words
// - Half-full falls at half depth plus one
// - Depth doubles when both ports narrow
// - Almost-full falls at depth minus offset
// - Full falls at depth; writes then ignored
// - First read when full raises full flag
// - Almost-empty falls when count reaches offset
// - Last read drops empty; reads then ignored
// - Empty and full use two stages each
// - Output ready three stages, input ready two
// - Fall-through capacity is depth plus one
module dual_clock_fifo_flag_logic
   import fifo_flag_pkg::*;
#(
   parameter bit BOTH_X9 = 1'b0
)
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_write_clk,
   input wire logic i_write_enable_n,
   input wire logic [DATA_W-1:0] i_data_in,
   input wire logic i_read_clk,
   input wire logic i_read_enable_n,
   input wire logic i_mode_select_serial_in,
   input wire logic i_master_reset_n,
   input wire logic [PTR_W-1:0] i_empty_offset,
   input wire logic [PTR_W-1:0] i_full_offset,
   output logic [DATA_W-1:0] o_data_out,
   output logic o_empty_flag_n,
   output logic o_full_flag_n,
   output logic o_almost_empty_n,
   output logic o_almost_full_n,
   output logic o_half_full_n
);

   // ----------------------------------------------------------------
   // Depth and thresholds
   // ----------------------------------------------------------------
   // depth select
   localparam int DEPTH = BOTH_X9 ? 2 * BASE_DEPTH : BASE_DEPTH;
   localparam int AW = $clog2(DEPTH);
   localparam logic [PTR_W-1:0] DEPTH_P = PTR_W'(DEPTH);
   localparam logic [PTR_W-1:0] HALF_P1 = PTR_W'(DEPTH / 2 + 1);
   localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);

   // ----------------------------------------------------------------
   // Storage and state
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] mem [DEPTH];
   fifo_state_type st;
   fifo_state_type next_st;

   pin_type raw_pins;
   pin_type pins;

   logic wr_edge;
   logic rd_edge;
   logic mem_we;
   logic [AW-1:0] mem_waddr;
   logic [PTR_W-1:0] w_used;
   logic [PTR_W-1:0] w_cnt;
   logic [PTR_W-1:0] r_cnt;
   logic r_avail;
   logic full_now;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Data rides the same two stages as the write clock, so the word
   // seen at a detected edge is the one set up before that edge.
   always_comb begin
      raw_pins.wclk = i_write_clk;
      raw_pins.wen_n = i_write_enable_n;
      raw_pins.din = i_data_in;
      raw_pins.rclk = i_read_clk;
      raw_pins.ren_n = i_read_enable_n;
      raw_pins.mode = i_mode_select_serial_in;
      raw_pins.mrst_n = i_master_reset_n;
   end

   pin_sync u_pin_sync (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_ce(i_ce),
      .i_pins(raw_pins),
      .o_pins(pins)
   );

   // ----------------------------------------------------------------
   // Pointer views
   // ----------------------------------------------------------------
   // Binary copies of the synchronised Gray pointers. Each bit is the
   // parity of the Gray bits at and above it, so no ripple chain forms
   // and every bit settles in one xor tree.
   logic [PTR_W-1:0] rg1_bin;
   logic [PTR_W-1:0] rg2_bin;
   logic [PTR_W-1:0] wg1_bin;
   logic [PTR_W-1:0] wg2_bin;

   for (genvar i = 0; i < PTR_W; i++) begin : g_gray_bin
      assign rg1_bin[i] = ^st.rg_s1[PTR_W-1:i];
      assign rg2_bin[i] = ^st.rg_s2[PTR_W-1:i];
      assign wg1_bin[i] = ^st.wg_s1[PTR_W-1:i];
      assign wg2_bin[i] = ^st.wg_s2[PTR_W-1:i];
   end

   // ----------------------------------------------------------------
   // Port events
   // ----------------------------------------------------------------
   logic wr_take;
   logic rd_want;
   logic rd_take;
   logic fall_through;
   logic [PTR_W-1:0] wptr_next;
   logic [PTR_W-1:0] rptr_next;

   // Port clocks are rises of the synchronised pin levels, found in the
   // first system cycle the level is high, but never twice for one pin edge
   assign wr_edge = pins.wclk & ~st.wclk_prev;
   assign rd_edge = pins.rclk & ~st.rclk_prev;

   // Mode as latched by the last master reset
   assign fall_through = (st.mode == MODE_FIRST_WORD_FALLTHROUGH_MODE);

   // Write side view: occupancy against the lagging read pointer,
   // which can only overstate the fill and so never overruns
   assign w_used = st.wptr - rg2_bin;
   assign full_now = (w_used == DEPTH_P);
   assign wr_take = wr_edge & ~pins.wen_n & ~full_now;
   assign wptr_next = st.wptr + PTR_W'(wr_take);

   // Data counts for the reader only once stage two holds it
   assign r_avail = (wg2_bin != st.rptr);
   // fall-through load
   // Standard reads wait for a request; fall-through also refills an
   // empty output register without one
   assign rd_want = ~pins.ren_n | (fall_through & ~st.out_valid);
   assign rd_take = r_avail & rd_want;
   assign rptr_next = st.rptr + PTR_W'(rd_take);

   // ----------------------------------------------------------------
   // Counts and thresholds
   // ----------------------------------------------------------------
   logic hf_hit;
   logic af_hit;
   logic full_hit;
   logic ae_clear;
   logic empty_hit;
   logic [PTR_W-1:0] af_level;

   // Write count uses the read pointer that becomes stage two now
   assign w_cnt = wptr_next - rg1_bin;
   // Read count leaves out the output word, so in fall-through the
   // same thresholds land one word later in total
   assign r_cnt = wg1_bin - rptr_next;

   // Offsets are taken as below the depth; a larger full offset wraps
   // and gives a meaningless almost-full level
   assign af_level = DEPTH_P - i_full_offset;

   // Write-side levels, only taken into state on write edges
   assign hf_hit = (w_cnt >= HALF_P1);
   assign af_hit = (w_cnt >= af_level);
   assign full_hit = (w_cnt == DEPTH_P);
   // Read-side levels, only taken into state on read edges
   assign ae_clear = (r_cnt > i_empty_offset);
   assign empty_hit = (r_cnt == '0);

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      mem_we = 1'b0;
      mem_waddr = st.wptr[AW-1:0];

      // Edge memories follow the synchronised pin levels
      next_st.wclk_prev = pins.wclk;
      next_st.rclk_prev = pins.rclk;

      if (!pins.mrst_n) begin
         next_st.mode = mode_type'(pins.mode);
         next_st.wptr = '0;
         next_st.wptr_g = '0;
         next_st.rptr = '0;
         next_st.rptr_g = '0;
         next_st.wg_s1 = '0;
         next_st.wg_s2 = '0;
         next_st.rg_s1 = '0;
         next_st.rg_s2 = '0;
         next_st.out_valid = 1'b0;
         next_st.data_out = '0;
         next_st.ae_n = RST_AE_N;
         next_st.af_n = RST_AF_N;
         next_st.hf_n = RST_HF_N;
         if (pins.mode) begin
            next_st.ef_n = RST_READY_OUT_N;
            next_st.ff_n = RST_READY_IN_N;
         end else begin
            next_st.ef_n = RST_EMPTY_N;
            next_st.ff_n = RST_FULL_N;
         end
      end else begin

         // ------------------------------------------------------------
         // Write port
         // ------------------------------------------------------------
         if (wr_edge) begin
            next_st.rg_s1 = st.rptr_g;
            next_st.rg_s2 = st.rg_s1;
            if (wr_take) begin
               mem_we = 1'b1;
               next_st.wptr = st.wptr + PTR_ONE;
               next_st.wptr_g = bin2gray(next_st.wptr);
            end
            next_st.hf_n = !hf_hit;
            next_st.af_n = !af_hit;
            if (st.mode == MODE_FIRST_WORD_FALLTHROUGH_MODE) begin
               next_st.ff_n = full_hit;
            end else begin
               next_st.ff_n = !full_hit;
            end
         end

         // ------------------------------------------------------------
         // Read port
         // ------------------------------------------------------------
         if (rd_edge) begin
            next_st.wg_s1 = st.wptr_g;
            next_st.wg_s2 = st.wg_s1;
            if (st.mode == MODE_STANDARD) begin
               if (!pins.ren_n && r_avail) begin
                  next_st.data_out = mem[st.rptr[AW-1:0]];
                  next_st.rptr = st.rptr + PTR_ONE;
               end
            end else begin
               if (r_avail && (!st.out_valid || !pins.ren_n)) begin
                  next_st.data_out = mem[st.rptr[AW-1:0]];
                  next_st.rptr = st.rptr + PTR_ONE;
                  next_st.out_valid = 1'b1;
               end else if (!pins.ren_n) begin
                  // Output word taken and nothing behind it
                  next_st.out_valid = 1'b0;
               end
            end
            next_st.rptr_g = bin2gray(next_st.rptr);

            next_st.ae_n = ae_clear;
            if (st.mode == MODE_FIRST_WORD_FALLTHROUGH_MODE) begin
               next_st.ef_n = !next_st.out_valid;
            end else begin
               next_st.ef_n = !empty_hit;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Storage write
   // ----------------------------------------------------------------
   // No reset on the array: contents are don't-care until written
   always_ff @(posedge i_clk) begin
      if (i_ce && mem_we) begin
         mem[mem_waddr] <= pins.din;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // The system reset leaves standard mode; the pin latch needs a
   // master reset pulse to pick fall-through.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st.mode <= MODE_STANDARD;
         st.wclk_prev <= 1'h0;
         st.rclk_prev <= 1'h0;
         st.wptr <= '0;
         st.wptr_g <= '0;
         st.rptr <= '0;
         st.rptr_g <= '0;
         st.wg_s1 <= '0;
         st.wg_s2 <= '0;
         st.rg_s1 <= '0;
         st.rg_s2 <= '0;
         st.out_valid <= 1'h0;
         st.data_out <= '0;
         st.ef_n <= RST_EMPTY_N;
         st.ff_n <= RST_FULL_N;
         st.ae_n <= RST_AE_N;
         st.af_n <= RST_AF_N;
         st.hf_n <= RST_HF_N;
      end else if (i_ce) begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, straight from state flip-flops
   // ----------------------------------------------------------------
   assign o_data_out = st.data_out;
   assign o_empty_flag_n = st.ef_n;
   assign o_full_flag_n = st.ff_n;
   assign o_almost_empty_n = st.ae_n;
   assign o_almost_full_n = st.af_n;
   assign o_half_full_n = st.hf_n;

endmodule

// ===== verif/fifo_flag_chk.sv
module fifo_flag_chk
   import fifo_flag_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_write_clk,
   input wire logic i_read_clk,
   input wire logic i_mode_select_serial_in,
   input wire logic i_master_reset_n,
   input wire logic [PTR_W-1:0] i_empty_offset,
   input wire logic [DATA_W-1:0] o_data_out,
   input wire logic o_empty_flag_n,
   input wire logic o_full_flag_n,
   input wire logic o_almost_empty_n,
   input wire logic o_almost_full_n,
   input wire logic o_half_full_n
);
   timeunit 1ns;
   timeprecision 100ps;
   logic fw, wp, rp;
   logic [3:0] wc, rc, mc;
   // Ages of the last port clock rises and of master reset release;
   // mode copy is taken straight from the pin, so it is guarded by mc
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         fw <= 1'h0;
         wp <= 1'h0;
         rp <= 1'h0;
         wc <= 4'hF;
         rc <= 4'hF;
         mc <= 4'h0;
      end else begin
         fw <= i_master_reset_n ? fw : i_mode_select_serial_in;
         wp <= i_write_clk;
         rp <= i_read_clk;
         wc <= (i_write_clk && !wp) ? 4'h0 : wc + 4'(wc != 4'hF);
         rc <= (i_read_clk && !rp) ? 4'h0 : rc + 4'(rc != 4'hF);
         mc <= i_master_reset_n ? mc + 4'(mc != 4'hF) : 4'h0;
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   // Flag relations that hold whatever the traffic
   a_mreset_flags: assert property (
      !i_master_reset_n [*4] |=> !o_almost_empty_n && o_almost_full_n
      && o_half_full_n) else $error("master reset flags");
   a_empty_holds: assert property (
      !fw && mc == 4'hF && !o_empty_flag_n && !$past(o_empty_flag_n)
      |-> $stable(o_data_out)) else $error("data moved when empty");
   a_half_ae_apart: assert property (
      !o_half_full_n && i_empty_offset < 11'h100 |-> o_almost_empty_n)
      else $error("half full and almost empty");
   a_full_af: assert property (
      !fw && mc == 4'hF && !o_full_flag_n |-> !o_almost_full_n
      && !o_half_full_n) else $error("full without almost full");
   a_empty_not_full: assert property (
      !fw && mc == 4'hF && !o_empty_flag_n |-> o_full_flag_n)
      else $error("empty and full");
   a_empty_ae: assert property (
      !fw && mc == 4'hF && i_empty_offset != 11'h0 && !o_empty_flag_n
      |-> !o_almost_empty_n) else $error("empty not almost empty");
   a_write_side: assert property (
      mc == 4'hF && ($changed(o_full_flag_n) || $changed(o_half_full_n)
      || $changed(o_almost_full_n)) |-> wc < 4'h8)
      else $error("write flag without write clock");
   a_read_side: assert property (
      mc == 4'hF && ($changed(o_empty_flag_n) || $changed(o_data_out)
      || $changed(o_almost_empty_n)) |-> rc < 4'h8)
      else $error("read flag without read clock");
endmodule

bind dual_clock_fifo_flag_logic fifo_flag_chk chk (
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_write_clk(i_write_clk),
   .i_read_clk(i_read_clk), .i_master_reset_n(i_master_reset_n),
   .i_mode_select_serial_in(i_mode_select_serial_in),
   .i_empty_offset(i_empty_offset), .o_data_out(o_data_out),
   .o_empty_flag_n(o_empty_flag_n), .o_full_flag_n(o_full_flag_n),
   .o_almost_empty_n(o_almost_empty_n), .o_almost_full_n(o_almost_full_n),
   .o_half_full_n(o_half_full_n));

// ===== verif/fifo_partner.sv
module fifo_partner
   import fifo_flag_pkg::*;
(
   output logic o_write_clk,
   output logic o_write_enable_n,
   output logic [DATA_W-1:0] o_data_in,
   output logic o_read_clk,
   output logic o_read_enable_n
);
   timeunit 1ns;
   timeprecision 100ps;
   // Idle port levels
   initial begin
      o_write_clk = 1'h0;
      o_write_enable_n = 1'h1;
      o_data_in = 18'h00000;
      o_read_enable_n = 1'h1;
   end
   // Port clocks run free at 125 ns
   always #62.5 o_write_clk = ~o_write_clk;
   // Read clock starts late so its edges never meet the write clock
   initial begin
      o_read_clk = 1'h0;
      #23;
      forever #62.5 o_read_clk = ~o_read_clk;
   end
   task automatic write(input logic [DATA_W-1:0] d);
      @(negedge o_write_clk);
      o_write_enable_n <= 1'h0;
      o_data_in <= d;
      @(negedge o_write_clk);
      o_write_enable_n <= 1'h1;
      o_data_in <= ~d; // Stale word cannot pass
   endtask
   task automatic read;
      @(negedge o_read_clk);
      o_read_enable_n <= 1'h0;
      @(negedge o_read_clk);
      o_read_enable_n <= 1'h1;
   endtask
endmodule

// ===== verif/dual_clock_fifo_flag_logic_bench.sv
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
   $display("wrong value at %0t: %h not %h", $time, a, b); end end
module dual_clock_fifo_flag_logic_bench
   import fifo_flag_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int D = BASE_DEPTH;
   localparam int N = 4;
   localparam int M = 8;
   logic i_clk = 1'h0;
   logic rst_n, mrst_n, mode, wclk, rclk, wen_n, ren_n;
   logic ef_n, ff_n, ae_n, af_n, hf_n;
   logic [DATA_W-1:0] din, dout;
   int fail_count = 0;
   int checks = 0;
   int c;
   // 250 MHz system clock
   always #2 i_clk = ~i_clk;
   // Writer and reader on their own clocks
   fifo_partner p (.o_write_clk(wclk), .o_write_enable_n(wen_n),
      .o_data_in(din), .o_read_clk(rclk), .o_read_enable_n(ren_n));
   // Offsets are fixed settings; loading them lies outside this block
   dual_clock_fifo_flag_logic dut (.i_clk(i_clk), .i_rst_n(rst_n),
      .i_ce(1'h1), .i_write_clk(wclk), .i_write_enable_n(wen_n),
      .i_data_in(din), .i_read_clk(rclk), .i_read_enable_n(ren_n),
      .i_mode_select_serial_in(mode), .i_master_reset_n(mrst_n),
      .i_empty_offset(11'(N)), .i_full_offset(11'(M)), .o_data_out(dout),
      .o_empty_flag_n(ef_n), .o_full_flag_n(ff_n),
      .o_almost_empty_n(ae_n), .o_almost_full_n(af_n),
      .o_half_full_n(hf_n));
   task automatic mreset(input logic m);
      @(posedge i_clk);
      mrst_n <= 1'h0;
      mode <= m;
      repeat (8) @(posedge i_clk);
      mrst_n <= 1'h1;
      repeat (8) @(posedge i_clk);
   endtask
   // Five read clock falls cover both two-stage crossings
   task automatic settle;
      repeat (5) @(negedge rclk);
   endtask
   task automatic final_report;
      $display("%0d checks, %0d mismatches", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Watchdog well above the planned run of some 270 us
   initial begin
      #360000;
      fail_count++;
      final_report();
   end
   // Standard mode, then a full fill and drain, then fall-through
   initial begin
      rst_n = 1'h0;
      mrst_n = 1'h1;
      mode = 1'h0;
      repeat (8) @(posedge i_clk);
      rst_n <= 1'h1;
      mreset(1'h0);
      `CHK({ef_n, ff_n, ae_n, af_n, hf_n}, 5'h0B)
      p.write(18'h15A5A);
      settle();
      `CHK(ef_n, 1'h1)
      p.read();
      `CHK({dout, ef_n}, {18'h15A5A, 1'h0})
      p.read();
      `CHK(dout, 18'h15A5A)
      $display("single word test done");
      // Flags checked after every write, almost-empty near its edge
      for (int k = 1; k <= D; k++) begin
         p.write(18'(k));
         `CHK({hf_n, af_n, ff_n}, {k < D/2+1, k < D-M, k < D})
         if (k <= N + 1) begin
            settle();
            `CHK(ae_n, k > N)
         end
      end
      p.write(18'h3FFFF);
      `CHK(ff_n, 1'h0)
      $display("fill test done");
      // Write-side flags lag reads, so they are checked after settling
      for (int k = 1; k <= D; k++) begin
         p.read();
         c = D - k;
         `CHK({dout, ae_n}, {18'(k), c > N})
         if (k == 1 || c == D/2 || c == D-M-1) begin
            settle();
            `CHK({ff_n, hf_n, af_n}, {1'h1, c < D/2+1, c < D-M})
         end
      end
      `CHK(ef_n, 1'h0)
      $display("drain test done");
      mreset(1'h1);
      `CHK({ef_n, ff_n}, 2'h2)
      p.write(18'h2A5A5);
      p.write(18'h0C3C3);
      settle();
      `CHK({dout, ef_n}, {18'h2A5A5, 1'h0})
      p.read();
      `CHK({dout, ef_n}, {18'h0C3C3, 1'h0})
      p.read();
      settle();
      `CHK(ef_n, 1'h1)
      $display("fall-through test done");
      final_report();
   end
endmodule
